// file: src/prfb_top.sv
// Two-port RAM/FIFO block with parity and threshold flags
`timescale 1ns/1ps
module prfb_top
   import prfb_pkg::*;
(
   // Core clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   // Write side pins
   input wire logic WRITE_CLOCK_I,
   input wire logic WRITE_SELECT_N_I,
   input wire logic WRITE_STROBE_N_I,
   input wire logic [ADDR_W-1:0] WRITE_ADDR_I,
   input wire logic [WORD_W-1:0] WRITE_WORD_I,
   // Read side pins
   input wire logic READ_CLOCK_I,
   input wire logic READ_SELECT_N_I,
   input wire logic READ_STROBE_N_I,
   input wire logic [ADDR_W-1:0] READ_ADDR_I,
   // Static configuration pins
   input wire logic FIFO_RESET_N_I,
   input wire logic ODD_PARITY_SEL_I,
   input wire logic PARITY_GENERATE_EN_I,
   input wire logic [ADDR_W-1:0] THRESHOLD_LEVEL_I,
   input wire logic [DLOG_W-1:0] DEPTH_LOG_FIELD_I,
   // Register port
   input wire logic [REG_AW-1:0] REG_ADDR_I,
   input wire logic [REG_DW-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [REG_DW-1:0] REG_RDATA_O,
   // Data and flag outputs
   output logic [WORD_W-1:0] READ_WORD_O,
   output logic READ_PARITY_ERR_O,
   output logic WRITE_PARITY_ERR_O,
   output logic FULL_O,
   output logic EMPTY_O,
   output logic AT_THRESHOLD_FLAG_O,
   output logic ABOVE_THRESHOLD_FLAG_O,
   output logic IRQ_O
);

   ////////////////////////////////////////////////////////////////////
   // Synchronised pin groups

   // Group widths
   localparam int WG_W = 3 + ADDR_W + WORD_W;
   localparam int RG_W = 3 + ADDR_W;
   localparam int CG_W = 3 + ADDR_W + DLOG_W;

   logic [WG_W-1:0] wgrp_s; // Write group after two flops
   logic [RG_W-1:0] rgrp_s; // Read group after two flops
   logic [CG_W-1:0] cgrp_s; // Config group after two flops

   // Write group: clock, select, strobe, address, word
   prfb_sync #(
      .W(WG_W)
   ) u_wsync (
      .clk_i(CORE_CLK_I),
      .d_i({WRITE_CLOCK_I, WRITE_SELECT_N_I, WRITE_STROBE_N_I,
            WRITE_ADDR_I, WRITE_WORD_I}),
      .q_o(wgrp_s)
   );

   // Read group: clock, select, strobe, address
   prfb_sync #(
      .W(RG_W)
   ) u_rsync (
      .clk_i(CORE_CLK_I),
      .d_i({READ_CLOCK_I, READ_SELECT_N_I, READ_STROBE_N_I,
            READ_ADDR_I}),
      .q_o(rgrp_s)
   );

   // Config group: pointer reset, parity, level, depth
   prfb_sync #(
      .W(CG_W)
   ) u_csync (
      .clk_i(CORE_CLK_I),
      .d_i({FIFO_RESET_N_I, ODD_PARITY_SEL_I, PARITY_GENERATE_EN_I,
            THRESHOLD_LEVEL_I, DEPTH_LOG_FIELD_I}),
      .q_o(cgrp_s)
   );

   // Unpacked write side
   wire logic wclk_s; // Write clock level
   wire logic wsel_n_s; // Write select, low active
   wire logic wstrb_n_s; // Write strobe, low active
   wire logic [ADDR_W-1:0] write_addr_s; // Write address
   wire logic [WORD_W-1:0] wword_s; // Write word
   assign {wclk_s, wsel_n_s, wstrb_n_s, write_addr_s, wword_s} = wgrp_s;

   // Unpacked read side
   wire logic rclk_s; // Read clock level
   wire logic rsel_n_s; // Read select, low active
   wire logic rstrb_n_s; // Read strobe, low active
   wire logic [ADDR_W-1:0] read_addr_s; // Read address
   assign {rclk_s, rsel_n_s, rstrb_n_s, read_addr_s} = rgrp_s;

   // Unpacked configuration
   wire logic frst_n_s; // Pointer reset, low active
   wire logic odd_s; // Odd parity when high
   wire logic gen_s; // Parity generation enable
   wire logic [ADDR_W-1:0] level_s; // Threshold level
   wire logic [DLOG_W-1:0] dlog_s; // Depth field
   assign {frst_n_s, odd_s, gen_s, level_s, dlog_s} = cgrp_s;

   ////////////////////////////////////////////////////////////////////
   // State

   logic wclk_prev_q; // Last write clock level
   logic rclk_prev_q; // Last read clock level
   logic fifo_mode_q; // FIFO mode when set, RAM when clear
   logic [ADDR_W-1:0] wptr_q; // FIFO write pointer
   logic [ADDR_W-1:0] wptr_d;
   logic [ADDR_W-1:0] rptr_q; // FIFO read pointer
   logic [ADDR_W-1:0] rptr_d;
   logic [CNT_W-1:0] count_q; // Words held
   logic [CNT_W-1:0] count_d;
   logic full_q; // Full flag
   logic empty_q; // Empty flag
   logic at_q; // Count equals level
   logic above_q; // Count at or over level
   logic above_d;
   logic wpe_q; // Last write parity result
   logic rpe_q; // Last read parity result
   logic rd_done_q; // Read data valid this cycle
   logic [EV_W-1:0] stat_q; // Sticky event bits
   logic [EV_W-1:0] stat_d;
   logic [EV_W-1:0] mask_q; // Interrupt mask
   logic [REG_DW-1:0] rdata_q; // Register read data
   logic [WORD_W-1:0] mem_rdata; // Word from the store

   ////////////////////////////////////////////////////////////////////
   // Edge detection and port qualification

   // Rising edges of the two port clocks
   wire logic wclk_rise = wclk_s & ~wclk_prev_q;
   wire logic rclk_rise = rclk_s & ~rclk_prev_q;

   // Write asks: edge with select and strobe low
   wire logic wr_fire = wclk_rise & ~wsel_n_s & ~wstrb_n_s;
   // Read asks: edge with select and strobe low
   wire logic rd_fire = rclk_rise & ~rsel_n_s & ~rstrb_n_s;

   // Full stops writes, empty stops reads, FIFO mode only
   wire logic wr_ok = wr_fire & ~(fifo_mode_q & full_q);
   wire logic rd_ok = rd_fire & ~(fifo_mode_q & empty_q);
   wire logic fifo_wr = wr_ok & fifo_mode_q;
   wire logic fifo_rd = rd_ok & fifo_mode_q;

   ////////////////////////////////////////////////////////////////////
   // Parity

   // Generated bit for the incoming data byte
   wire logic gen_bit = par_gen(wword_s[DATA_W-1:0], odd_s);

   // Stored word: generated bit replaces bit eight when enabled
   wire logic [WORD_W-1:0] store_word = gen_s ?
      {gen_bit, wword_s[DATA_W-1:0]} : wword_s;

   // Supplied word checked only when not generating
   wire logic wpe_now = ~gen_s & par_chk(wword_s, odd_s);

   // Read word checked once it is out of the store
   wire logic rpe_now = par_chk(mem_rdata, odd_s);

   ////////////////////////////////////////////////////////////////////
   // Addressing and depth

   // Depth and pointer wrap mask from the depth field
   wire logic [CNT_W-1:0] depth = fifo_depth(dlog_s);
   wire logic [ADDR_W-1:0] wrap = ADDR_W'(depth - CNT_ONE);

   // RAM mode takes pin addresses, FIFO mode pointers
   wire logic [ADDR_W-1:0] mem_write_addr =
      fifo_mode_q ? wptr_q : write_addr_s;
   wire logic [ADDR_W-1:0] mem_read_addr =
      fifo_mode_q ? rptr_q : read_addr_s;

   // Word store
   prfb_mem u_mem (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .we_i(wr_ok),
      .write_addr_i(mem_write_addr),
      .wdata_i(store_word),
      .re_i(rd_ok),
      .read_addr_i(mem_read_addr),
      .rdata_o(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////
   // Pointer and count arithmetic

   // Pointers advance and wrap at the configured depth
   always_comb begin
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      if (fifo_wr) begin
         wptr_d = (wptr_q + PTR_ONE) & wrap;
      end
      if (fifo_rd) begin
         rptr_d = (rptr_q + PTR_ONE) & wrap;
      end
   end

   // Count moves by accepted FIFO writes and reads only
   always_comb begin
      unique case ({fifo_wr, fifo_rd})
         2'b10: count_d = count_q + CNT_ONE; // Write only
         2'b01: count_d = count_q - CNT_ONE; // Read only
         default: count_d = count_q; // Both or none
      endcase
   end

   // Threshold compare on the next count
   assign above_d = fifo_mode_q &
      (count_d >= CNT_W'(level_s));

   ////////////////////////////////////////////////////////////////////
   // FIFO state

   // Pointers, count and flags; pointer reset empties the FIFO
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I || !frst_n_s) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
         full_q <= 1'b0;
         empty_q <= 1'b1;
         at_q <= 1'b0;
         above_q <= 1'b0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         count_q <= count_d;
         // Flags follow the count the next cycle sees
         full_q <= count_d >= depth;
         empty_q <= count_d == '0;
         at_q <= fifo_mode_q &
            (count_d == CNT_W'(level_s));
         above_q <= above_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Port clock history and parity results

   // Edge history; under reset it tracks the pin, no false edge
   always_ff @(posedge CORE_CLK_I) begin
      wclk_prev_q <= wclk_s;
      rclk_prev_q <= rclk_s;
   end

   // Write error follows each accepted write
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         wpe_q <= 1'b0;
      end else if (wr_ok) begin
         wpe_q <= wpe_now;
      end
   end

   // Read error follows each word leaving the store
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         rd_done_q <= 1'b0;
         rpe_q <= 1'b0;
      end else begin
         rd_done_q <= rd_ok;
         if (rd_done_q) begin
            rpe_q <= rpe_now;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Events and interrupt

   // Event pulses for the sticky status
   wire logic [EV_W-1:0] ev;
   assign ev[EV_WPE] = wr_ok & wpe_now;
   assign ev[EV_RPE] = rd_done_q & rpe_now;
   assign ev[EV_OVF] = wr_fire & fifo_mode_q & full_q;
   assign ev[EV_UDF] = rd_fire & fifo_mode_q & empty_q;
   assign ev[EV_THR] = above_d & ~above_q;

   // Status read clears; a new event in that cycle wins
   wire logic stat_rd = REG_RD_I & (REG_ADDR_I == REG_STAT);
   assign stat_d = (stat_q & ~{EV_W{stat_rd}}) | ev;

   // Register writes
   wire logic ctrl_wr = REG_WR_I & (REG_ADDR_I == REG_CTRL);
   wire logic mask_wr = REG_WR_I & (REG_ADDR_I == REG_MASK);

   // Control, mask and status registers
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         fifo_mode_q <= CTRL_FIFO_RST;
         mask_q <= MASK_RST;
         stat_q <= '0;
      end else begin
         stat_q <= stat_d;
         if (ctrl_wr) begin
            fifo_mode_q <= REG_WDATA_I[CTRL_FIFO_BIT];
         end
         if (mask_wr) begin
            mask_q <= REG_WDATA_I[EV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register read path

   // Read words for each register
   wire logic [REG_DW-1:0] ctrl_word = REG_DW'(fifo_mode_q);
   wire logic [REG_DW-1:0] stat_word = REG_DW'(stat_q);
   wire logic [REG_DW-1:0] mask_word = REG_DW'(mask_q);
   wire logic [REG_DW-1:0] state_word =
      REG_DW'({full_q, empty_q, count_q});

   // Selection; unmapped indices read zero
   wire logic [REG_DW-1:0] rd_mux =
      (REG_ADDR_I == REG_CTRL) ? ctrl_word :
      (REG_ADDR_I == REG_STAT) ? stat_word :
      (REG_ADDR_I == REG_MASK) ? mask_word :
      (REG_ADDR_I == REG_STATE) ? state_word : '0;

   // Read data stand one cycle, zero otherwise
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= REG_RD_I ? rd_mux : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign REG_RDATA_O = rdata_q;
   assign READ_WORD_O = mem_rdata;
   assign READ_PARITY_ERR_O = rpe_q;
   assign WRITE_PARITY_ERR_O = wpe_q;
   assign FULL_O = full_q;
   assign EMPTY_O = empty_q;
   assign AT_THRESHOLD_FLAG_O = at_q;
   assign ABOVE_THRESHOLD_FLAG_O = above_q;
   // Level interrupt while any unmasked status bit stands
   assign IRQ_O = |(stat_q & mask_q);

endmodule

// file: src/prfb_pkg.sv
// Package: widths, register map, event bits and parity helpers
package prfb_pkg;
   // Memory geometry
   localparam int ADDR_W = 8;
   localparam int WORD_W = 9;
   localparam int DATA_W = 8;
   localparam int CNT_W = 9;
   localparam int DLOG_W = 3;
   localparam int DEPTH_MAX = 256;
   localparam logic [ADDR_W-1:0] PTR_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   // Register port geometry
   localparam int REG_AW = 4;
   localparam int REG_DW = 16;
   // Register indices
   localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
   localparam logic [REG_AW-1:0] REG_STAT = 4'h1;
   localparam logic [REG_AW-1:0] REG_MASK = 4'h2;
   localparam logic [REG_AW-1:0] REG_STATE = 4'h3;
   // Control field and its reset value
   localparam int CTRL_FIFO_BIT = 0;
   localparam logic CTRL_FIFO_RST = 1'b0;
   // Event bits of status and mask
   localparam int EV_W = 5;
   localparam int EV_WPE = 0;
   localparam int EV_RPE = 1;
   localparam int EV_OVF = 2;
   localparam int EV_UDF = 3;
   localparam int EV_THR = 4;
   localparam logic [EV_W-1:0] MASK_RST = 5'h00;
   // Generated parity bit for eight data bits
   function automatic logic par_gen(input logic [DATA_W-1:0] d,
                                    input logic odd);
      return (^d) ^ odd;
   endfunction
   // Mismatch of a nine-bit word against the selected parity
   function automatic logic par_chk(input logic [WORD_W-1:0] w,
                                    input logic odd);
      return (^w) ^ odd;
   endfunction
   // Number of words for a depth field value
   function automatic logic [CNT_W-1:0] fifo_depth(
      input logic [DLOG_W-1:0] lg);
      return CNT_ONE << (32'(lg) + 1);
   endfunction
endpackage

// file: src/prfb_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module prfb_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q; // First stage, read only by second
   logic [W-1:0] sync_q; // Second stage, safe to use
   ////////////////////////////////////////////////////////////////////
   // No reset: pure pipeline, settles two cycles after any change
   always_ff @(posedge clk_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
   end
   assign q_o = sync_q;
endmodule

// file: src/prfb_mem.sv
// 256 x 9 word store with registered read data
`timescale 1ns/1ps
module prfb_mem
   import prfb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] write_addr_i,
   input wire logic [WORD_W-1:0] wdata_i,
   input wire logic re_i,
   input wire logic [ADDR_W-1:0] read_addr_i,
   output logic [WORD_W-1:0] rdata_o
);
   logic [WORD_W-1:0] mem_q [DEPTH_MAX]; // Word array
   logic [WORD_W-1:0] rdata_q; // Read data register
   ////////////////////////////////////////////////////////////////////
   // Write port
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[write_addr_i] <= wdata_i;
      end
   end
   // Read port, old data on a same-cycle collision
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else if (re_i) begin
         rdata_q <= mem_q[read_addr_i];
      end
   end
   assign rdata_o = rdata_q;
endmodule

// file: testbench/prfb_chk.sv
// Port assertions for the two-port RAM/FIFO block
`timescale 1ns/1ps
module prfb_chk
   import prfb_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic FIFO_RESET_N_I,
   input wire logic ODD_PARITY_SEL_I,
   input wire logic [ADDR_W-1:0] THRESHOLD_LEVEL_I,
   input wire logic [REG_AW-1:0] REG_ADDR_I,
   input wire logic [REG_DW-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [REG_DW-1:0] REG_RDATA_O,
   input wire logic [WORD_W-1:0] READ_WORD_O,
   input wire logic READ_PARITY_ERR_O,
   input wire logic FULL_O,
   input wire logic EMPTY_O,
   input wire logic AT_THRESHOLD_FLAG_O,
   input wire logic ABOVE_THRESHOLD_FLAG_O,
   input wire logic IRQ_O
);
   // Single core domain for all checks
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////////////////////////////////
   // Outputs still at reset values on the release edge
   property p_reset_vals;
      $rose(RST_N_I) |-> EMPTY_O && !FULL_O && !IRQ_O;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("outputs not at reset values after release");
   // Pointer reset held long enough empties the store
   property p_fifo_reset;
      !FIFO_RESET_N_I [*5] |-> EMPTY_O && !FULL_O && !ABOVE_THRESHOLD_FLAG_O;
   endproperty
   a_fifo_reset: assert property (p_fifo_reset)
      else $error("pointer reset left words in the store");
   // Full and empty never together
   property p_full_empty;
      !(FULL_O && EMPTY_O);
   endproperty
   a_full_empty: assert property (p_full_empty)
      else $error("full and empty both high");
   // Equal count implies at-or-above count
   property p_eq_geq;
      AT_THRESHOLD_FLAG_O |-> ABOVE_THRESHOLD_FLAG_O;
   endproperty
   a_eq_geq: assert property (p_eq_geq)
      else $error("equal flag without at-or-above flag");
   // Empty store is below any nonzero level
   property p_empty_below;
      EMPTY_O && THRESHOLD_LEVEL_I != 8'h00 && $stable(THRESHOLD_LEVEL_I)
         |-> !ABOVE_THRESHOLD_FLAG_O;
   endproperty
   a_empty_below: assert property (p_empty_below)
      else $error("at-or-above flag while empty");
   // Read error follows the new word one cycle later
   property p_read_par;
      $changed(READ_WORD_O) && $stable(ODD_PARITY_SEL_I) |=>
         READ_PARITY_ERR_O == ((^READ_WORD_O) ^ ODD_PARITY_SEL_I);
   endproperty
   a_read_par: assert property (p_read_par)
      else $error("read parity error disagrees with word");
   // Read data is zero outside the answer cycle
   property p_rdata_zero;
      !$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000;
   endproperty
   a_rdata_zero: assert property (p_rdata_zero)
      else $error("read data outside answer cycle");
   // Unmapped indices read as zero
   property p_unmapped;
      REG_RD_I && REG_ADDR_I > REG_STATE |=> REG_RDATA_O == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped index read nonzero");
   // Clearing the mask drops the interrupt
   property p_mask_off;
      REG_WR_I && REG_ADDR_I == REG_MASK && REG_WDATA_I == 16'h0000
         ##1 !REG_WR_I |-> ##1 !IRQ_O;
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("interrupt high with all events masked");
   // Main scenarios reached
   c_full: cover property (FULL_O);
   c_irq: cover property ($rose(IRQ_O));
   c_rpe: cover property (READ_PARITY_ERR_O);
endmodule
bind prfb_top prfb_chk prfb_chk_i (
   .CORE_CLK_I, .RST_N_I, .FIFO_RESET_N_I, .ODD_PARITY_SEL_I,
   .THRESHOLD_LEVEL_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
   .REG_RDATA_O, .READ_WORD_O, .READ_PARITY_ERR_O, .FULL_O, .EMPTY_O,
   .AT_THRESHOLD_FLAG_O, .ABOVE_THRESHOLD_FLAG_O, .IRQ_O
);

// file: testbench/prfb_user.sv
// Fabric user logic driving both port pin groups
`timescale 1ns/1ps
module prfb_user
   import prfb_pkg::*;
(
   input wire logic clk_i,
   output logic wclk_o,
   output logic wsel_n_o,
   output logic wstb_n_o,
   output logic [ADDR_W-1:0] write_addr_o,
   output logic [WORD_W-1:0] wword_o,
   output logic rclk_o,
   output logic rsel_n_o,
   output logic rstb_n_o,
   output logic [ADDR_W-1:0] read_addr_o
);
   // Idle: pin clocks low, selects and strobes high
   initial begin
      {wclk_o, rclk_o, write_addr_o, read_addr_o, wword_o} = '0;
      {wsel_n_o, wstb_n_o, rsel_n_o, rstb_n_o} = 4'hF;
   end
   // One write pin cycle with setup and hold
   task automatic put(input logic sn, input logic tn,
                      input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w);
      @(posedge clk_i);
      wsel_n_o <= sn;
      wstb_n_o <= tn;
      write_addr_o <= a;
      wword_o <= w;
      repeat (4) @(posedge clk_i);
      wclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      wclk_o <= 1'b0;
      {wsel_n_o, wstb_n_o} <= 2'h3;
      wword_o <= ~w;
      repeat (4) @(posedge clk_i);
   endtask
   // One read pin cycle with setup and hold
   task automatic get(input logic sn, input logic tn,
                      input logic [ADDR_W-1:0] a);
      @(posedge clk_i);
      rsel_n_o <= sn;
      rstb_n_o <= tn;
      read_addr_o <= a;
      repeat (4) @(posedge clk_i);
      rclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      rclk_o <= 1'b0;
      {rsel_n_o, rstb_n_o} <= 2'h3;
      read_addr_o <= ~a;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// file: testbench/prfb_top_bench.sv
// Self-checking bench for the RAM/FIFO block
`timescale 1ns/1ps
module prfb_top_bench;
   import prfb_pkg::*;
   localparam int DEP = 4; // Depth field 1 gives four words
   logic CORE_CLK_I, RST_N_I, WRITE_CLOCK_I, WRITE_SELECT_N_I;
   logic WRITE_STROBE_N_I, READ_CLOCK_I, READ_SELECT_N_I, READ_STROBE_N_I;
   logic FIFO_RESET_N_I, ODD_PARITY_SEL_I, PARITY_GENERATE_EN_I;
   logic REG_WR_I, REG_RD_I, READ_PARITY_ERR_O, WRITE_PARITY_ERR_O;
   logic FULL_O, EMPTY_O, AT_THRESHOLD_FLAG_O, ABOVE_THRESHOLD_FLAG_O, IRQ_O;
   logic [ADDR_W-1:0] WRITE_ADDR_I, READ_ADDR_I, THRESHOLD_LEVEL_I, a;
   logic [WORD_W-1:0] WRITE_WORD_I, READ_WORD_O, w, last;
   logic [DLOG_W-1:0] DEPTH_LOG_FIELD_I;
   logic [REG_AW-1:0] REG_ADDR_I;
   logic [REG_DW-1:0] REG_WDATA_I, REG_RDATA_O, d;
   logic [31:0] seed = 32'd35;
   logic [WORD_W-1:0] q[$]; // Model store contents
   int mismatches = 0;
   int total_checks = 0;
   prfb_top prfb_top_i (.*);
   prfb_user prfb_user_i (.clk_i(CORE_CLK_I), .wclk_o(WRITE_CLOCK_I),
      .wsel_n_o(WRITE_SELECT_N_I), .wstb_n_o(WRITE_STROBE_N_I),
      .write_addr_o(WRITE_ADDR_I), .wword_o(WRITE_WORD_I),
      .rclk_o(READ_CLOCK_I), .rsel_n_o(READ_SELECT_N_I),
      .rstb_n_o(READ_STROBE_N_I), .read_addr_o(READ_ADDR_I));
   // Core clock, 5 ns period
   initial begin
      CORE_CLK_I = 1'b0;
      forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
   end
   // Random source
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Compare and count
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Store flags against the model count
   task automatic flags(input int n);
      chk("empty", 16'(n == 0), 16'(EMPTY_O));
      chk("full", 16'(n >= DEP), 16'(FULL_O));
      chk("at_level", 16'(n == 2), 16'(AT_THRESHOLD_FLAG_O));
      chk("above_level", 16'(n >= 2), 16'(ABOVE_THRESHOLD_FLAG_O));
   endtask
   // Register write and read, one strobe cycle each
   task automatic reg_wr(input logic [REG_AW-1:0] ad, input logic [15:0] v);
      @(posedge CORE_CLK_I);
      {REG_WR_I, REG_ADDR_I, REG_WDATA_I} <= {1'b1, ad, v};
      @(posedge CORE_CLK_I);
      REG_WR_I <= 1'b0;
      // Step past the taking edge so callers see the new register value
      #1;
   endtask
   task automatic reg_rd(input logic [REG_AW-1:0] ad, output logic [15:0] v);
      @(posedge CORE_CLK_I);
      {REG_RD_I, REG_ADDR_I} <= {1'b1, ad};
      @(posedge CORE_CLK_I);
      REG_RD_I <= 1'b0;
      #1 v = REG_RDATA_O;
   endtask
   // Store write with generated parity
   task automatic fw();
      seed = xs(seed);
      prfb_user_i.put(1'b0, 1'b0, 8'h00, seed[8:0]);
      if (q.size() < DEP) q.push_back({^seed[7:0] ^ ODD_PARITY_SEL_I,
                                      seed[7:0]});
      chk("gen_wpe", 16'h0000, 16'(WRITE_PARITY_ERR_O));
      flags(q.size());
   endtask
   // Verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (50000) @(posedge CORE_CLK_I);
      mismatches++;
      conclude();
   end
   // Main sequence
   initial begin
      {RST_N_I, REG_WR_I, REG_RD_I, REG_ADDR_I, REG_WDATA_I} = '0;
      {ODD_PARITY_SEL_I, PARITY_GENERATE_EN_I, FIFO_RESET_N_I} = 3'h1;
      THRESHOLD_LEVEL_I = 8'h02;
      DEPTH_LOG_FIELD_I = 3'h1;
      repeat (4) @(posedge CORE_CLK_I);
      RST_N_I <= 1'b1;
      repeat (3) @(posedge CORE_CLK_I);
      reg_rd(REG_CTRL, d);
      chk("ctrl_rst", 16'h0000, d);
      reg_rd(REG_MASK, d);
      chk("mask_rst", 16'h0000, d);
      reg_rd(REG_STATE, d);
      chk("state_rst", 16'h0200, d);
      reg_rd(4'hF, d);
      chk("unmapped", 16'h0000, d);
      $display("reset test done");
      // RAM mode: write, refused writes, read back
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         {a, w} = seed[16:0];
         ODD_PARITY_SEL_I <= seed[20];
         prfb_user_i.put(1'b0, 1'b0, a, w);
         chk("wpe", 16'(^w ^ ODD_PARITY_SEL_I), 16'(WRITE_PARITY_ERR_O));
         prfb_user_i.put(1'b1, 1'b0, a, ~w);
         prfb_user_i.put(1'b0, 1'b1, a, ~w);
         prfb_user_i.get(1'b0, 1'b0, a);
         chk("ram_word", 16'(w), 16'(READ_WORD_O));
         chk("rpe", 16'(^w ^ ODD_PARITY_SEL_I), 16'(READ_PARITY_ERR_O));
         prfb_user_i.get(1'b0, 1'b1, a ^ 8'h01);
         prfb_user_i.get(1'b1, 1'b0, a ^ 8'h01);
         chk("word_held", 16'(w), 16'(READ_WORD_O));
      end
      flags(0);
      reg_rd(REG_STAT, d);
      $display("ram test done");
      // FIFO mode: fill past full, then interrupt mask and clear
      PARITY_GENERATE_EN_I <= 1'b1;
      reg_wr(REG_MASK, 16'h0001 << EV_OVF);
      reg_wr(REG_CTRL, 16'h0001);
      for (int i = 0; i < DEP + 1; i++) fw();
      chk("irq_ovf", 16'h0001, 16'(IRQ_O));
      reg_wr(REG_MASK, 16'h0000);
      chk("irq_masked", 16'h0000, 16'(IRQ_O));
      reg_wr(REG_MASK, 16'h0001 << EV_OVF);
      reg_rd(REG_STAT, d);
      chk("status", (16'h0001 << EV_OVF) | (16'h0001 << EV_THR), d);
      repeat (3) @(posedge CORE_CLK_I);
      chk("irq_clear", 16'h0000, 16'(IRQ_O));
      // Drain past empty with random read parity
      for (int i = 0; i < DEP + 1; i++) begin
         seed = xs(seed);
         if (i < DEP) ODD_PARITY_SEL_I <= seed[0];
         prfb_user_i.get(1'b0, 1'b0, 8'h00);
         if (q.size() > 0) last = q.pop_front();
         chk("fifo_word", 16'(last), 16'(READ_WORD_O));
         chk("fifo_rpe", 16'(^last ^ ODD_PARITY_SEL_I), 16'(READ_PARITY_ERR_O));
         flags(q.size());
      end
      chk("irq_udf_masked", 16'h0000, 16'(IRQ_O));
      reg_rd(REG_STAT, d);
      chk("underflow", 16'h0001 << EV_UDF, d & (16'h0001 << EV_UDF));
      $display("fifo test done");
      // Pointer reset with words held
      fw();
      fw();
      FIFO_RESET_N_I <= 1'b0;
      repeat (6) @(posedge CORE_CLK_I);
      FIFO_RESET_N_I <= 1'b1;
      q.delete();
      repeat (4) @(posedge CORE_CLK_I);
      flags(0);
      reg_rd(REG_STATE, d);
      chk("state_clear", 16'h0200, d);
      $display("pointer reset test done");
      conclude();
   end
endmodule
